//--- rtl/vost_top.v
// video output alignment, timing code insertion and horizontal sync
`timescale 1ns/1ps
`default_nettype none
`include "vost_consts.vh"
module vost_top #(
  parameter DW        = 8,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW   = 4,
  parameter TAPS      = 11
) (
  input  wire          ref_clk_in,
  input  wire          rst_b_in,
  input  wire          line_locked_pixel_clock_in,
  input  wire [DW-1:0] luma_in,
  input  wire [DW-1:0] chroma_in,
  input  wire          trc_req_in,
  input  wire          trc_h_in,
  input  wire          trc_v_in,
  input  wire          trc_f_in,
  input  wire [1:0]    input_fmt_in,
  input  wire [1:0]    std_sel_in,
  input  wire [7:0]    reg_addr_in,
  input  wire [7:0]    reg_wdata_in,
  input  wire          reg_wr_in,
  input  wire          reg_rd_in,
  output reg  [7:0]    reg_rdata_out,
  output wire [DW-1:0] vid_data_out,
  output wire          vid_valid_out,
  input  wire          vid_ready_in,
  output reg           hsync_out
);

  ////////////////////////////////////////////////////////////////////////////
  // link inputs: three flops, a change counts once stages two and three agree
  reg [2:0]    clk_sync;
  reg          clk_level;
  reg [DW-1:0] luma_s1, luma_s2, luma_s3;
  reg [DW-1:0] chroma_s1, chroma_s2, chroma_s3;
  reg [3:0]    trc_s1, trc_s2, trc_s3;
  wire         pix_edge;

  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      clk_sync  <= 3'h0;
      clk_level <= 1'b0;
      luma_s1   <= {DW{1'b0}};
      luma_s2   <= {DW{1'b0}};
      luma_s3   <= {DW{1'b0}};
      chroma_s1 <= {DW{1'b0}};
      chroma_s2 <= {DW{1'b0}};
      chroma_s3 <= {DW{1'b0}};
      trc_s1    <= 4'h0;
      trc_s2    <= 4'h0;
      trc_s3    <= 4'h0;
    end else begin
      clk_sync  <= {clk_sync[1:0], line_locked_pixel_clock_in};
      luma_s1   <= luma_in;
      luma_s2   <= luma_s1;
      luma_s3   <= luma_s2;
      chroma_s1 <= chroma_in;
      chroma_s2 <= chroma_s1;
      chroma_s3 <= chroma_s2;
      trc_s1    <= {trc_req_in, trc_f_in, trc_v_in, trc_h_in};
      trc_s2    <= trc_s1;
      trc_s3    <= trc_s2;
      if (clk_sync[1] == clk_sync[2]) begin
        clk_level <= clk_sync[2];
      end
    end
  end

  // one pulse per accepted rising edge of the pixel clock
  assign pix_edge = (clk_sync[1] == clk_sync[2]) && clk_sync[2] && !clk_level;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg [7:0] dly_ctrl;
  reg [7:0] hs_hi;
  reg [7:0] hs_start_lo;
  reg [7:0] hs_stop_lo;
  reg [7:0] pol_ctrl;
  reg       overflow;
  reg       hs_active;
  reg [10:0] line_cnt;
  wire      ovf_event;
  wire      ovf_clear;

  assign ovf_clear = reg_wr_in && (reg_addr_in == `VOST_ADDR_STAT) &&
                     reg_wdata_in[`VOST_STAT_OVF];

  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dly_ctrl    <= `VOST_RST_DLY;
      hs_hi       <= `VOST_RST_HSHI;
      hs_start_lo <= `VOST_RST_HSSTART;
      hs_stop_lo  <= `VOST_RST_HSSTOP;
      pol_ctrl    <= `VOST_RST_POL;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `VOST_ADDR_DLY: dly_ctrl <= reg_wdata_in;
        `VOST_ADDR_HSHI: hs_hi <= reg_wdata_in;
        `VOST_ADDR_HSSTART: hs_start_lo <= reg_wdata_in;
        `VOST_ADDR_HSSTOP: hs_stop_lo <= reg_wdata_in;
        `VOST_ADDR_POL: pol_ctrl <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // sticky overflow: a new overflow wins over a clear in the same cycle
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      overflow <= 1'b0;
    end else if (ovf_event) begin
      overflow <= 1'b1;
    end else if (ovf_clear) begin
      overflow <= 1'b0;
    end
  end

  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `VOST_ADDR_DLY: reg_rdata_out <= dly_ctrl;
        `VOST_ADDR_HSHI: reg_rdata_out <= hs_hi;
        `VOST_ADDR_HSSTART: reg_rdata_out <= hs_start_lo;
        `VOST_ADDR_HSSTOP: reg_rdata_out <= hs_stop_lo;
        `VOST_ADDR_POL: reg_rdata_out <= pol_ctrl;
        `VOST_ADDR_STAT: reg_rdata_out <= {6'h00, hs_active, overflow};
        `VOST_ADDR_LCNT_LO: reg_rdata_out <= line_cnt[7:0];
        `VOST_ADDR_LCNT_HI: reg_rdata_out <= {5'h00, line_cnt[10:8]};
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // delay selection
  function [3:0] luma_tap;
    input [1:0] code;
    begin
      case (code)
        `VOST_LTA_NONE: luma_tap = `VOST_TAP_BASE;
        `VOST_LTA_LATE1: luma_tap = `VOST_TAP_BASE + `VOST_TAP_ONE;
        `VOST_LTA_EARLY2: luma_tap = `VOST_TAP_BASE - `VOST_TAP_STEP;
        `VOST_LTA_EARLY1: luma_tap = `VOST_TAP_BASE - `VOST_TAP_ONE;
        default: luma_tap = `VOST_TAP_BASE;
      endcase
    end
  endfunction

  // one chroma pixel is two luma clocks, so chroma taps move in steps of two
  function [3:0] chroma_tap;
    input [2:0] code;
    begin
      case (code)
        `VOST_CTA_EARLY2: chroma_tap = `VOST_TAP_BASE - 4'h4;
        `VOST_CTA_EARLY1: chroma_tap = `VOST_TAP_BASE - `VOST_TAP_STEP;
        `VOST_CTA_NONE: chroma_tap = `VOST_TAP_BASE;
        `VOST_CTA_LATE1: chroma_tap = `VOST_TAP_BASE + `VOST_TAP_STEP;
        `VOST_CTA_LATE2: chroma_tap = `VOST_TAP_BASE + 4'h4;
        `VOST_CTA_LATE3: chroma_tap = `VOST_TAP_LAST;
        // unused codes are treated as no shift
        default: chroma_tap = `VOST_TAP_BASE;
      endcase
    end
  endfunction

  reg [1:0] lta_eff;
  reg [2:0] cta_eff;

  always @* begin
    if (dly_ctrl[`VOST_AUTO_BIT]) begin
      // automatic mode picks the settings matching the input format
      case (input_fmt_in)
        `VOST_FMT_YC: begin
          lta_eff = `VOST_LTA_LATE1;
          cta_eff = `VOST_CTA_LATE2;
        end
        `VOST_FMT_COMP: begin
          lta_eff = `VOST_LTA_LATE1;
          cta_eff = `VOST_CTA_LATE3;
        end
        default: begin
          lta_eff = `VOST_LTA_NONE;
          cta_eff = `VOST_CTA_NONE;
        end
      endcase
    end else begin
      lta_eff = dly_ctrl[`VOST_LTA_MSB:`VOST_LTA_LSB];
      cta_eff = dly_ctrl[`VOST_CTA_MSB:`VOST_CTA_LSB];
    end
  end

  wire [DW-1:0] luma_dly;
  wire [DW-1:0] chroma_dly;

  vost_tap_delay #(
    .WIDTH (DW),
    .DEPTH (TAPS),
    .SELW  (4)
  ) u_luma_dly (
    .clk_in   (ref_clk_in),
    .rst_b_in (rst_b_in),
    .shift_in (pix_edge),
    .data_in  (luma_s3),
    .tap_in   (luma_tap(lta_eff)),
    .data_out (luma_dly)
  );

  vost_tap_delay #(
    .WIDTH (DW),
    .DEPTH (TAPS),
    .SELW  (4)
  ) u_chroma_dly (
    .clk_in   (ref_clk_in),
    .rst_b_in (rst_b_in),
    .shift_in (pix_edge),
    .data_in  (chroma_s3),
    .tap_in   (chroma_tap(cta_eff)),
    .data_out (chroma_dly)
  );

  ////////////////////////////////////////////////////////////////////////////
  // timing code insertion and word interleave
  localparam [3:0] ST_DATA = 4'b0001;
  localparam [3:0] ST_Z1   = 4'b0010;
  localparam [3:0] ST_Z2   = 4'b0100;
  localparam [3:0] ST_XY   = 4'b1000;

  reg [3:0]    state;
  reg [3:0]    next_state;
  reg [2:0]    trc_flags;
  reg          word_phase;
  reg [DW-1:0] word;
  reg          word_valid;
  reg [DW-1:0] next_word;
  reg          eav_done;
  wire [7:0]   status_word;

  // status word: 1, f, v, h and four protection bits
  assign status_word = {1'b1, trc_flags[2], trc_flags[1], trc_flags[0],
                        trc_flags[1] ^ trc_flags[0],
                        trc_flags[2] ^ trc_flags[0],
                        trc_flags[2] ^ trc_flags[1],
                        trc_flags[2] ^ trc_flags[1] ^ trc_flags[0]};

  always @* begin
    next_state = state;
    next_word  = word_phase ? luma_dly : chroma_dly;
    case (state)
      ST_DATA: begin
        if (trc_s3[3]) begin
          next_word  = `VOST_TRC_HDR1;
          next_state = ST_Z1;
        end
      end
      ST_Z1: begin
        next_word  = `VOST_TRC_HDR0;
        next_state = ST_Z2;
      end
      ST_Z2: begin
        next_word  = `VOST_TRC_HDR0;
        next_state = ST_XY;
      end
      ST_XY: begin
        next_word  = status_word;
        next_state = ST_DATA;
      end
      default: begin
        next_state = ST_DATA;
      end
    endcase
  end

  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state      <= ST_DATA;
      trc_flags  <= 3'h0;
      word_phase <= 1'b0;
      word       <= {DW{1'b0}};
      word_valid <= 1'b0;
      eav_done   <= 1'b0;
    end else begin
      word_valid <= pix_edge;
      eav_done   <= pix_edge && (state == ST_XY) && trc_flags[0];
      if (pix_edge) begin
        state <= next_state;
        word  <= next_word;
        if (state == ST_DATA && trc_s3[3]) begin
          trc_flags <= trc_s3[2:0];
        end
        // chroma word leads again after every code
        word_phase <= (state == ST_XY) ? 1'b0 : !word_phase;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line counter and horizontal sync; neither touches the code words
  reg  [10:0] line_last;
  wire [10:0] hs_start_pos;
  wire [10:0] hs_stop_pos;

  assign hs_start_pos = {hs_hi[`VOST_HSB_HI_MSB:`VOST_HSB_HI_LSB], hs_start_lo};
  assign hs_stop_pos  = {hs_hi[`VOST_HSE_HI_MSB:`VOST_HSE_HI_LSB], hs_stop_lo};

  always @* begin
    case (std_sel_in)
      `VOST_STD_SQ: line_last = `VOST_LINE_SQ - `VOST_LINE_ONE;
      `VOST_STD_625: line_last = `VOST_LINE_625 - `VOST_LINE_ONE;
      default: line_last = `VOST_LINE_525 - `VOST_LINE_ONE;
    endcase
  end

  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      line_cnt <= `VOST_LINE_ZERO;
    end else if (eav_done) begin
      line_cnt <= `VOST_LINE_ZERO;
    end else if (pix_edge) begin
      if (line_cnt >= line_last) begin
        line_cnt <= `VOST_LINE_ZERO;
      end else begin
        line_cnt <= line_cnt + `VOST_LINE_ONE;
      end
    end
  end

  // start wins when start and stop are equal, giving a full line pulse
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hs_active <= 1'b0;
      hsync_out <= 1'b0;
    end else begin
      if (line_cnt == hs_start_pos) begin
        hs_active <= 1'b1;
      end else if (line_cnt == hs_stop_pos) begin
        hs_active <= 1'b0;
      end
      hsync_out <= hs_active ^ pol_ctrl[`VOST_PHS_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output fifo; the pixel clock cannot be held, so a full fifo drops the
  // word and raises the sticky overflow flag
  wire fifo_ready;

  assign ovf_event = word_valid && !fifo_ready;

  vost_fifo #(
    .WIDTH (DW),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_in       (ref_clk_in),
    .rst_b_in     (rst_b_in),
    .wr_valid_in  (word_valid),
    .wr_ready_out (fifo_ready),
    .wr_data_in   (word),
    .rd_valid_out (vid_valid_out),
    .rd_ready_in  (vid_ready_in),
    .rd_data_out  (vid_data_out)
  );

endmodule // vost_top
`default_nettype wire

//--- rtl/vost_consts.vh
// constants for the video output sync timing block
`ifndef VOST_CONSTS_VH
`define VOST_CONSTS_VH
`define VOST_ADDR_DLY      8'h27
`define VOST_ADDR_HSHI     8'h34
`define VOST_ADDR_HSSTART  8'h35
`define VOST_ADDR_HSSTOP   8'h36
`define VOST_ADDR_POL      8'h37
`define VOST_ADDR_STAT     8'hF0
`define VOST_ADDR_LCNT_LO  8'hF1
`define VOST_ADDR_LCNT_HI  8'hF2
`define VOST_RST_DLY       8'h58
`define VOST_RST_HSHI      8'h00
`define VOST_RST_HSSTART   8'h02
`define VOST_RST_HSSTOP    8'h00
`define VOST_RST_POL       8'h00
`define VOST_AUTO_BIT      6
`define VOST_CTA_MSB       5
`define VOST_CTA_LSB       3
`define VOST_LTA_MSB       1
`define VOST_LTA_LSB       0
`define VOST_HSB_HI_MSB    6
`define VOST_HSB_HI_LSB    4
`define VOST_HSE_HI_MSB    2
`define VOST_HSE_HI_LSB    0
`define VOST_PHS_BIT       7
`define VOST_STAT_OVF      0
`define VOST_STAT_HS       1
`define VOST_LINE_525      11'h6B4
`define VOST_LINE_SQ       11'h618
`define VOST_LINE_625      11'h6C0
`define VOST_STD_525       2'h0
`define VOST_STD_SQ        2'h1
`define VOST_STD_625       2'h2
`define VOST_FMT_CVBS      2'h0
`define VOST_FMT_YC        2'h1
`define VOST_FMT_COMP      2'h2
`define VOST_LTA_NONE      2'h0
`define VOST_LTA_LATE1     2'h1
`define VOST_LTA_EARLY2    2'h2
`define VOST_LTA_EARLY1    2'h3
`define VOST_CTA_EARLY2    3'h1
`define VOST_CTA_EARLY1    3'h2
`define VOST_CTA_NONE      3'h3
`define VOST_CTA_LATE1     3'h4
`define VOST_CTA_LATE2     3'h5
`define VOST_CTA_LATE3     3'h6
`define VOST_TAP_BASE      4'h4
`define VOST_TAP_STEP      4'h2
`define VOST_TAP_ONE       4'h1
`define VOST_TAP_LAST      4'hA
`define VOST_TRC_HDR1      8'hFF
`define VOST_TRC_HDR0      8'h00
`define VOST_LINE_ZERO     11'h000
`define VOST_LINE_ONE      11'h001
`endif

//--- rtl/vost_fifo.v
// sixteen word fifo with registered read data
`timescale 1ns/1ps
`default_nettype none
module vost_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_in,
  input  wire             rst_b_in,
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  input  wire [WIDTH-1:0] wr_data_in,
  output reg              rd_valid_out,
  input  wire             rd_ready_in,
  output reg  [WIDTH-1:0] rd_data_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr;
  reg [AW:0]      rd_ptr;
  wire            empty = (wr_ptr == rd_ptr);
  wire            full  = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
  wire            pop   = !empty && (!rd_valid_out || rd_ready_in);
  assign wr_ready_out = !full;
  always @(posedge clk_in) begin
    if (wr_valid_in && !full) begin
      mem[wr_ptr[AW-1:0]] <= wr_data_in;
    end
  end
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ptr       <= {(AW+1){1'b0}};
      rd_ptr       <= {(AW+1){1'b0}};
      rd_valid_out <= 1'b0;
      rd_data_out  <= {WIDTH{1'b0}};
    end else begin
      if (wr_valid_in && !full) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr       <= rd_ptr + 1'b1;
        rd_data_out  <= mem[rd_ptr[AW-1:0]];
        rd_valid_out <= 1'b1;
      end else if (rd_ready_in) begin
        rd_valid_out <= 1'b0;
      end
    end
  end
endmodule // vost_fifo
`default_nettype wire

//--- rtl/vost_tap_delay.v
// shift register delay line with a selectable tap
`timescale 1ns/1ps
`default_nettype none
module vost_tap_delay #(
  parameter WIDTH = 8,
  parameter DEPTH = 11,
  parameter SELW  = 4
) (
  input  wire             clk_in,
  input  wire             rst_b_in,
  input  wire             shift_in,
  input  wire [WIDTH-1:0] data_in,
  input  wire [SELW-1:0]  tap_in,
  output wire [WIDTH-1:0] data_out
);
  wire [WIDTH-1:0] stage [0:DEPTH-1];
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_stage
      reg  [WIDTH-1:0] q;
      wire [WIDTH-1:0] d;
      // stage zero must not name a neighbour below index zero
      if (i == 0) begin : g_head
        assign d = data_in;
      end else begin : g_body
        assign d = stage[i-1];
      end
      always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          q <= {WIDTH{1'b0}};
        end else if (shift_in) begin
          q <= d;
        end
      end
      assign stage[i] = q;
    end
  endgenerate
  // out of range taps fall back to the last stage
  assign data_out = (tap_in < DEPTH) ? stage[tap_in] : stage[DEPTH-1];
endmodule // vost_tap_delay
`default_nettype wire

//--- bench/vost_properties.sv
// port level checks for the video output sync timing block
`timescale 1ns/1ps
`default_nettype none
module vost_chk #(
  parameter DW = 8
) (
  input wire logic          ref_clk_in,
  input wire logic          rst_b_in,
  input wire logic [7:0]    reg_addr_in,
  input wire logic [7:0]    reg_wdata_in,
  input wire logic          reg_wr_in,
  input wire logic          reg_rd_in,
  input wire logic [7:0]    reg_rdata_out,
  input wire logic [DW-1:0] vid_data_out,
  input wire logic          vid_valid_out,
  input wire logic          vid_ready_in,
  input wire logic          hsync_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////////////////////////////////////////////
  // sync pin idles low so the default polarity reads as active high
  a_rst_quiet: assert property (
    $rose(rst_b_in) |-> !hsync_out && !vid_valid_out && reg_rdata_out == 8'h00)
    else $error("outputs not idle after reset");
  a_rd_hold: assert property (
    !reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data moved without a read");
  // the far side may stall any time, a word must not be lost or changed
  a_vid_hold: assert property (
    vid_valid_out && !vid_ready_in |=> vid_valid_out && $stable(vid_data_out))
    else $error("stalled word not held");
  a_start_back: assert property (
    reg_wr_in && reg_addr_in == 8'h35 ##1 reg_rd_in && !reg_wr_in && reg_addr_in == 8'h35
    |=> reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("sync start readback wrong");
  a_stop_back: assert property (
    reg_wr_in && reg_addr_in == 8'h36 ##1 reg_rd_in && !reg_wr_in && reg_addr_in == 8'h36
    |=> reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("sync stop readback wrong");
  a_high_back: assert property (
    reg_wr_in && reg_addr_in == 8'h34 ##1 reg_rd_in && !reg_wr_in && reg_addr_in == 8'h34
    |=> (reg_rdata_out & 8'h77) == ($past(reg_wdata_in, 2) & 8'h77))
    else $error("sync high bits readback wrong");
  a_pol_back: assert property (
    reg_wr_in && reg_addr_in == 8'h37 ##1 reg_rd_in && !reg_wr_in && reg_addr_in == 8'h37
    |=> (reg_rdata_out & 8'h80) == ($past(reg_wdata_in, 2) & 8'h80))
    else $error("polarity readback wrong");
  a_dly_back: assert property (
    reg_wr_in && reg_addr_in == 8'h27 ##1 reg_rd_in && !reg_wr_in && reg_addr_in == 8'h27
    |=> (reg_rdata_out & 8'h7B) == ($past(reg_wdata_in, 2) & 8'h7B))
    else $error("alignment control readback wrong");
  a_cnt_width: assert property (
    reg_rd_in && !reg_wr_in && reg_addr_in == 8'hF2 |=> reg_rdata_out[7:3] == 5'h00)
    else $error("line counter wider than eleven bits");
endmodule // vost_chk
`default_nettype wire

//--- bench/vost_sink.sv
// downstream pixel receiver model with stall and slow modes
`timescale 1ns/1ps
`default_nettype none
module vost_sink (
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic [7:0] data_in,
  input  wire logic       valid_in,
  input  wire logic       stall_in,
  input  wire logic       slow_in,
  output wire logic       ready_out
);
  logic [7:0] words [0:4095];
  int         count;
  logic       tog;
  // slow mode takes every other cycle, like a busy encoder
  assign ready_out = !stall_in && (!slow_in || tog);
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tog   <= 1'b0;
      count <= 0;
    end else begin
      tog <= !tog;
      if (valid_in && ready_out) begin
        words[count[11:0]] <= data_in;
        count              <= count + 1;
      end
    end
  end
endmodule // vost_sink
`default_nettype wire

//--- bench/tb_top.sv
// self checking bench for the video output sync timing block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top;
  logic       clk, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, stall = 1'b0, slow = 1'b0;
  logic       pclk = 1'b0, trc_req = 1'b0, trc_pend = 1'b0, trc_f = 1'b0, trc_v = 1'b0;
  logic       ready, valid, hs, trc_h = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, luma = 8'h10, rdata, vdata;
  logic [1:0] fmt = 2'h0, std = 2'h0;
  logic [2:0] ph = 3'h0;
  int         err_count = 0, total_checks = 0, edge_n = 0, code_e = 0;
  logic [7:0] rst_a [5] = '{8'h27, 8'h34, 8'h35, 8'h36, 8'h37};
  logic [7:0] rst_v [5] = '{8'h58, 8'h00, 8'h02, 8'h00, 8'h00};
  int         lofs [4] = '{0, 1, -2, -1};
  int         rec_lo [3] = '{0, 1, 1};
  int         rec_cc [3] = '{3, 5, 6};
  vost_top DUT (
    .ref_clk_in(clk), .rst_b_in(rst_b), .line_locked_pixel_clock_in(pclk),
    .luma_in(luma), .chroma_in(luma + 8'h80), .trc_req_in(trc_req), .trc_h_in(trc_h),
    .trc_v_in(trc_v), .trc_f_in(trc_f), .input_fmt_in(fmt), .std_sel_in(std),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .vid_data_out(vdata), .vid_valid_out(valid),
    .vid_ready_in(ready), .hsync_out(hs));
  vost_sink u_sink (
    .clk_in(clk), .rst_b_in(rst_b), .data_in(vdata), .valid_in(valid),
    .stall_in(stall), .slow_in(slow), .ready_out(ready));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // pixel clock of 8 ref cycles; data moves at its fall so it is settled at the rise
  always @(negedge clk) begin
    ph <= ph + 3'h1;
    if (ph == 3'h0) begin
      pclk   <= 1'b1;
      edge_n <= edge_n + 1;
    end
    if (ph == 3'h4) begin
      pclk     <= 1'b0;
      luma     <= luma + 8'h01;
      trc_req  <= trc_pend;
      trc_pend <= 1'b0;
      if (trc_pend)
        code_e <= edge_n + 4;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic hang(input logic bad);
    if (bad) begin
      err_count++;
      stop_test();
    end
  endtask
  // every write is read straight back so the readback checks see it
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd   = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d  = rdata;
  endtask
  task automatic send_code(output int e);
    int n;
    n = 0;
    @(posedge clk);
    trc_pend = 1'b1;
    while (trc_pend && n < 20) begin
      @(posedge clk);
      n++;
    end
    hang(n >= 20);
    @(negedge clk);
    e = code_e;
  endtask
  task automatic wait_hs(input logic v, input logic pol, input int lim);
    int n;
    n = 0;
    while (((hs ^ pol) !== v) && n < lim) begin
      @(negedge clk);
      n++;
    end
    hang(n >= lim);
  endtask
  task automatic hs_line(input logic [1:0] s, input int tot, input logic pol,
                         input logic [10:0] st, input logic [10:0] sp);
    int e, e2;
    reg_wr(8'h37, {pol, 7'h00});
    reg_wr(8'h34, {1'b0, st[10:8], 1'b0, sp[10:8]});
    reg_wr(8'h35, st[7:0]);
    reg_wr(8'h36, sp[7:0]);
    std = s;
    // a pulse still open from the old settings would hide the first start
    wait_hs(1'b0, pol, tot * 8 + 100);
    send_code(e);
    wait_hs(1'b1, pol, st * 8 + 200);
    `CHK(edge_n, e + st)
    wait_hs(1'b0, pol, 400);
    `CHK(edge_n, e + sp)
    // a start of line code must not restart the counter
    trc_h = 1'b0;
    send_code(e2);
    wait_hs(1'b1, pol, tot * 8 + 100);
    trc_h = 1'b1;
    `CHK(edge_n, e + st + tot)
  endtask
  function automatic logic [7:0] w(input int i);
    return u_sink.words[i[11:0]];
  endfunction
  task automatic dly_case(input logic [7:0] r, input logic [7:0] ex, input logic [1:0] f);
    int e, i, c0, n;
    reg_wr(8'h27, r);
    fmt   = f;
    trc_f = f[0];
    trc_v = f[1];
    c0    = u_sink.count;
    send_code(e);
    n = 0;
    while (u_sink.count < c0 + 24 && n < 800) begin
      @(negedge clk);
      n++;
    end
    hang(n >= 800);
    i = c0;
    while (i < c0 + 18 && !(w(i) == 8'hFF && w(i + 1) == 8'h00 && w(i + 2) == 8'h00))
      i++;
    `CHK(w(i), 8'hFF)
    `CHK(w(i + 3), {1'b1, f[0], f[1], 1'b1, ~f[1], ~f[0], f[0] ^ f[1], ~(f[0] ^ f[1])})
    `CHK(8'(w(i + 5) - w(i + 4) + 8'h80), ex)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int         lo, cc, f, x;
    logic [7:0] d;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    for (int i = 0; i < 5; i++) begin
      reg_rd(rst_a[i], d);
      `CHK(d, rst_v[i])
    end
    reg_wr(8'h10, 8'h5A);
    `CHK(rdata, 8'h00)
    // pulses moved 20 and 276 pixels toward active video from a 2..6 base
    hs_line(2'h0, 1716, 1'b0, 11'd22, 11'd26);
    hs_line(2'h1, 1560, 1'b0, 11'd22, 11'd26);
    hs_line(2'h2, 1728, 1'b1, 11'd278, 11'd282);
    reg_rd(8'hF2, d);
    `CHK(d[7:3], 5'h00)
    for (int i = 0; i < 13; i++) begin
      lo = (i < 4) ? i : 0;
      cc = (i < 4) ? 3 : i - 3;
      f  = (i < 10) ? 0 : i - 10;
      if (i >= 10) begin
        lo = rec_lo[f];
        cc = rec_cc[f];
      end
      slow = (i >= 10);
      x    = 1 + 2 * (cc - 3) - lofs[lo];
      // auto cases carry junk manual fields that must be ignored
      dly_case((i >= 10) ? 8'h4A : {2'b00, cc[2:0], 1'b0, lo[1:0]}, x[7:0], f[1:0]);
    end
    stall = 1'b1;
    repeat (200) @(negedge clk);
    reg_rd(8'hF0, d);
    `CHK(d[0], 1'b1)
    stall = 1'b0;
    x     = 0;
    while (valid !== 1'b0 && x < 400) begin
      @(negedge clk);
      x++;
    end
    `CHK(valid, 1'b0)
    reg_wr(8'hF0, 8'h01);
    `CHK(rdata[0], 1'b0)
    stop_test();
  end
endmodule // tb_top
bind vost_top vost_chk #(.DW(DW)) u_chk (
  .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .vid_data_out(vid_data_out),
  .vid_valid_out(vid_valid_out), .vid_ready_in(vid_ready_in), .hsync_out(hsync_out));
`default_nettype wire
